// *** wdt_pkg.sv ***
// Constants, register map and state types of the watchdog reset timer.
// Assumes one 100 MHz clock and a classic Wishbone register bus.
package wdt_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [5:0] OFS_CTRL_STATUS = 6'h00;
   localparam logic [5:0] OFS_COUNT_VALUE = 6'h04;
   localparam logic [5:0] OFS_CLOCK_CHOICE = 6'h08;
   localparam logic [5:0] OFS_IRQ_STATUS = 6'h0C;
   localparam logic [5:0] OFS_IRQ_CLEAR = 6'h10;
   localparam logic [5:0] OFS_IRQ_ENABLE = 6'h14;

   // ------------------------------------------------------------
   // Control/status and clock choice bit positions
   // ------------------------------------------------------------
   localparam int BIT_COUNT_WE_INHIBIT = 7;
   localparam int BIT_COUNT_WRITE_ENABLE = 6;
   localparam int BIT_CTRL_WE_INHIBIT = 5;
   localparam int BIT_CTRL_WRITE_ENABLE = 4;
   localparam int BIT_RUN_INHIBIT = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_FLAG_INHIBIT = 1;
   localparam int BIT_RESET_FLAG = 0;
   localparam int BIT_CLK_SRC = 3;

   // Interrupt status bits
   localparam int IRQ_OVERFLOW = 0;
   localparam int IRQ_BLOCKED_WRITE = 1;
   localparam int IRQ_W = 2;

   // ------------------------------------------------------------
   // Reset values, reserved read value and counter maximum
   // ------------------------------------------------------------
   localparam logic [7:0] RST_COUNT_VALUE = 8'h00;
   localparam logic [3:0] RST_CLOCK_SELECT = 4'hF;
   localparam logic [3:0] CLOCK_CHOICE_RSVD = 4'hF;
   localparam logic [7:0] COUNT_MAX = 8'hFF;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   // Smallest prescaled division is 2**6 = 64, the largest 2**13 = 8192
   localparam int PRESC_BASE_LOG2 = 6;
   localparam int PRESC_W_DEFAULT = 13;
   // Internal reset pulse length in oscillator periods
   localparam int RESET_PULSE_OSC = 512;
   localparam int RESET_CNT_W = 10;

   // ------------------------------------------------------------
   // Bus carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [5:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wdt_wb_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wdt_wb_rsp_s;

   // ------------------------------------------------------------
   // Whole state of the block
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] count;
      logic run;
      logic count_write_enable;
      logic ctrl_write_enable;
      logic reset_flag;
      logic [3:0] clock_select_field;
      logic [PRESC_W_DEFAULT-1:0] presc;
      logic [1:0] osc_sync;
      logic osc_prev;
      logic [1:0] ext_rst_sync;
      logic chip_reset;
      logic [RESET_CNT_W-1:0] reset_cnt;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_enable;
      logic ack;
      logic [7:0] rdata;
   } wdt_state_s;

endpackage : wdt_pkg

// *** wdt_top.sv ***
// Watchdog reset timer: 8-bit up-counter, write-protected control,
// prescaler or oscillator count source, internal reset pulse.
// Assumes a classic Wishbone master on ref_clk and asynchronous
// oscillator and external reset pin inputs.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns

// Overview of operation
// - Counter wrap asserts reset, sets flag
// - Counter loads zero on reset
// - Counter writes need count write enable
// - Count enable changes only with bit7 zero
// - Control enable changes only with bit5 zero
// - Run and flag need control enable
// - Run written only with bit3 zero
// - Count while run, hold otherwise
// - Flag clears on pin or guarded zero
// - Inhibit bits always read one
// - Clock select picks divider or oscillator
// - Upper select bits read one, reset ones
// - Oscillator count ignores system clock stop
// - Counting starts from preset value
// - Internal reset lasts 512 oscillator cycles
module wdt_top #(
   parameter int PRESC_W = wdt_pkg::PRESC_W_DEFAULT
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Wishbone slave
   input wire wdt_pkg::wdt_wb_req_s wb_req,
   output wdt_pkg::wdt_wb_rsp_s wb_rsp,
   // Chip side
   input wire logic external_reset_pin_n,
   input wire logic osc_clk_in,
   input wire logic sys_clk_stop,
   output logic chip_reset_o,
   output logic irq_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   wdt_pkg::wdt_state_s st_r;
   wdt_pkg::wdt_state_s st_nxt;

   logic req;
   logic wr_go;
   logic [7:0] wbyte;
   logic osc_tick;
   logic presc_tick;
   logic count_tick;
   logic ext_rst;
   logic overflow;
   logic [PRESC_W-1:0] div_mask;
   logic [7:0] ctrl_view;
   logic [7:0] rd_mux;

   // ------------------------------------------------------------
   // Count sources
   // ------------------------------------------------------------
   assign osc_tick = st_r.osc_sync[1] & ~st_r.osc_prev;
   assign ext_rst = ~st_r.ext_rst_sync[1];

   always_comb begin
      div_mask = '0;
      for (int i = 0; i < PRESC_W; i++) begin
         if (i < wdt_pkg::PRESC_BASE_LOG2 + int'(st_r.clock_select_field[2:0])) begin
            div_mask[i] = 1'b1;
         end
      end
   end

   // System clock stop only gates the divider
   assign presc_tick = ((st_r.presc[PRESC_W-1:0] & div_mask) == div_mask) & ~sys_clk_stop;

   // Oscillator when the top select bit is zero
   assign count_tick = st_r.clock_select_field[wdt_pkg::BIT_CLK_SRC] ? presc_tick : osc_tick;

   assign overflow = st_r.run & count_tick & (st_r.count == wdt_pkg::COUNT_MAX);

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign req = wb_req.cyc & wb_req.stb;
   // Writes land on the edge where the master sees ack
   assign wr_go = req & st_r.ack & wb_req.we & wb_req.sel[0];
   assign wbyte = wb_req.dat[7:0];

   // Inhibit bits always read as one
   always_comb begin
      ctrl_view = 8'hFF;
      ctrl_view[wdt_pkg::BIT_COUNT_WRITE_ENABLE] = st_r.count_write_enable;
      ctrl_view[wdt_pkg::BIT_CTRL_WRITE_ENABLE] = st_r.ctrl_write_enable;
      ctrl_view[wdt_pkg::BIT_RUN] = st_r.run;
      ctrl_view[wdt_pkg::BIT_RESET_FLAG] = st_r.reset_flag;
   end

   always_comb begin
      case (wb_req.adr)
         wdt_pkg::OFS_CTRL_STATUS: begin
            rd_mux = ctrl_view;
         end
         wdt_pkg::OFS_COUNT_VALUE: begin
            rd_mux = st_r.count;
         end
         // Reserved upper bits read as one
         wdt_pkg::OFS_CLOCK_CHOICE: begin
            rd_mux = {wdt_pkg::CLOCK_CHOICE_RSVD, st_r.clock_select_field};
         end
         wdt_pkg::OFS_IRQ_STATUS: begin
            rd_mux = {{(8 - wdt_pkg::IRQ_W){1'b0}}, st_r.irq_status};
         end
         wdt_pkg::OFS_IRQ_ENABLE: begin
            rd_mux = {{(8 - wdt_pkg::IRQ_W){1'b0}}, st_r.irq_enable};
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic blocked;
      logic [wdt_pkg::IRQ_W-1:0] ev;
      blocked = 1'b0;
      ev = '0;
      st_nxt = st_r;

      // Synchronisers; first stage feeds only the second
      st_nxt.osc_sync = {st_r.osc_sync[0], osc_clk_in};
      st_nxt.osc_prev = st_r.osc_sync[1];
      st_nxt.ext_rst_sync = {st_r.ext_rst_sync[0], external_reset_pin_n};
      st_nxt.presc = st_r.presc + 1'b1;

      // Bus handshake: one wait state, ack for one cycle
      st_nxt.ack = req & ~st_r.ack;
      st_nxt.rdata = (req & ~st_r.ack) ? rd_mux : st_r.rdata;

      if (st_r.run && count_tick) begin
         // Counts up from whatever was preset
         st_nxt.count = st_r.count + 8'h01;
      end

      if (wr_go) begin
         case (wb_req.adr)
            wdt_pkg::OFS_CTRL_STATUS: begin
               // Each protected bit judged on its own
               // Count enable guarded by bit 7
               if (!wbyte[wdt_pkg::BIT_COUNT_WE_INHIBIT]) begin
                  st_nxt.count_write_enable = wbyte[wdt_pkg::BIT_COUNT_WRITE_ENABLE];
               end
               // Control enable guarded by bit 5
               if (!wbyte[wdt_pkg::BIT_CTRL_WE_INHIBIT]) begin
                  st_nxt.ctrl_write_enable = wbyte[wdt_pkg::BIT_CTRL_WRITE_ENABLE];
               end
               // Old enable value gates run and flag
               // Enabling and starting need separate writes
               if (st_r.ctrl_write_enable && !wbyte[wdt_pkg::BIT_RUN_INHIBIT]) begin
                  st_nxt.run = wbyte[wdt_pkg::BIT_RUN];
               end
               if (st_r.ctrl_write_enable && !wbyte[wdt_pkg::BIT_FLAG_INHIBIT]
                   && !wbyte[wdt_pkg::BIT_RESET_FLAG]) begin
                  st_nxt.reset_flag = 1'b0;
               end
               blocked = ~st_r.ctrl_write_enable
                  & (~wbyte[wdt_pkg::BIT_RUN_INHIBIT] | ~wbyte[wdt_pkg::BIT_FLAG_INHIBIT]);
            end
            wdt_pkg::OFS_COUNT_VALUE: begin
               if (st_r.count_write_enable) begin
                  st_nxt.count = wbyte;
               end else begin
                  blocked = 1'b1;
               end
            end
            wdt_pkg::OFS_CLOCK_CHOICE: begin
               st_nxt.clock_select_field = wbyte[3:0];
            end
            wdt_pkg::OFS_IRQ_ENABLE: begin
               st_nxt.irq_enable = wbyte[wdt_pkg::IRQ_W-1:0];
            end
            wdt_pkg::OFS_IRQ_CLEAR: begin
               st_nxt.irq_status = st_r.irq_status & ~wbyte[wdt_pkg::IRQ_W-1:0];
            end
            default: begin
               st_nxt.irq_status = st_nxt.irq_status;
            end
         endcase
      end

      // Overflow sets the flag; it beats a same-cycle write clear but not the pin
      if (overflow) begin
         st_nxt.reset_flag = 1'b1;
      end

      // Pulse counted on oscillator edges; overflow restarts it
      if (overflow) begin
         st_nxt.chip_reset = 1'b1;
         st_nxt.reset_cnt = '0;
      end else if (st_r.chip_reset && osc_tick) begin
         if (st_r.reset_cnt == (wdt_pkg::RESET_CNT_W)'(wdt_pkg::RESET_PULSE_OSC - 1)) begin
            st_nxt.chip_reset = 1'b0;
            st_nxt.reset_cnt = '0;
         end else begin
            st_nxt.reset_cnt = st_r.reset_cnt + 1'b1;
         end
      end

      // Sticky interrupt events: set wins over clear
      ev[wdt_pkg::IRQ_OVERFLOW] = overflow;
      ev[wdt_pkg::IRQ_BLOCKED_WRITE] = blocked;
      st_nxt.irq_status = st_nxt.irq_status | ev;

      // External pin resets the control registers but not interrupts or a running pulse
      if (ext_rst) begin
         st_nxt.count = wdt_pkg::RST_COUNT_VALUE;
         st_nxt.run = 1'b0;
         st_nxt.count_write_enable = 1'b0;
         st_nxt.ctrl_write_enable = 1'b0;
         st_nxt.reset_flag = 1'b0;
         st_nxt.clock_select_field = wdt_pkg::RST_CLOCK_SELECT;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_r.count <= wdt_pkg::RST_COUNT_VALUE;
         st_r.run <= 1'b0;
         st_r.count_write_enable <= 1'b0;
         st_r.ctrl_write_enable <= 1'b0;
         st_r.reset_flag <= 1'b0;
         st_r.clock_select_field <= wdt_pkg::RST_CLOCK_SELECT;
         st_r.presc <= '0;
         st_r.osc_sync <= 2'h0;
         st_r.osc_prev <= 1'b0;
         // Pin assumed released so reset does not linger
         st_r.ext_rst_sync <= 2'h3;
         st_r.chip_reset <= 1'b0;
         st_r.reset_cnt <= '0;
         st_r.irq_status <= '0;
         st_r.irq_enable <= '0;
         st_r.ack <= 1'b0;
         st_r.rdata <= 8'h00;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_rsp.ack = st_r.ack;
   assign wb_rsp.dat = {24'h000000, st_r.rdata};
   assign chip_reset_o = st_r.chip_reset;
   assign irq_o = |(st_r.irq_status & st_r.irq_enable);

endmodule : wdt_top

// *** wdt_top_asserts.sv ***
// Concurrent checks on the ports of the watchdog reset timer.
// Assumes a classic Wishbone master that holds its request until ack.
`timescale 1ns/1ns
module wdt_top_asserts #(
   parameter int PRESC_W = 13
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic srst,
   // Bus
   input wire wdt_pkg::wdt_wb_req_s wb_req,
   input wire wdt_pkg::wdt_wb_rsp_s wb_rsp,
   // Chip side
   input wire logic external_reset_pin_n,
   input wire logic osc_clk_in,
   input wire logic sys_clk_stop,
   input wire logic chip_reset_o,
   input wire logic irq_o
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   logic [2:0] osc_q;
   logic [9:0] edg_q;
   logic srst_q;
   // Own oscillator sync may sit one edge off the design's, so bound loosely
   always_ff @(posedge ref_clk) begin
      osc_q <= {osc_q[1:0], osc_clk_in};
      srst_q <= srst;
      if (!chip_reset_o) begin
         edg_q <= 10'h000;
      end else if (osc_q[1] && !osc_q[2]) begin
         edg_q <= edg_q + 10'h001;
      end
   end
   property p_ack_next;
      wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack late");
   property p_ack_once;
      wb_rsp.ack |=> !wb_rsp.ack;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_hi_zero;
      wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h000000;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
   property p_ctrl_ones;
      wb_rsp.ack && !wb_req.we && wb_req.adr == wdt_pkg::OFS_CTRL_STATUS
         |-> (wb_rsp.dat[7:0] & 8'hAA) == 8'hAA;
   endproperty
   a_ctrl_ones: assert property (p_ctrl_ones) else $error("inhibit bit low");
   property p_choice_ones;
      wb_rsp.ack && !wb_req.we && wb_req.adr == wdt_pkg::OFS_CLOCK_CHOICE
         |-> wb_rsp.dat[7:4] == 4'hF;
   endproperty
   a_choice_ones: assert property (p_choice_ones) else $error("reserved low");
   property p_rst_quiet;
      disable iff (1'b0) srst |=> !chip_reset_o && !wb_rsp.ack && !irq_o;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("active in reset");
   property p_pulse_hold;
      $rose(chip_reset_o) |-> chip_reset_o [*8];
   endproperty
   a_pulse_hold: assert property (p_pulse_hold) else $error("pulse short");
   property p_pulse_len;
      $fell(chip_reset_o) && !srst_q |-> edg_q >= 10'h1FE;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse too few edges");
endmodule : wdt_top_asserts

bind wdt_top wdt_top_asserts #(.PRESC_W(PRESC_W)) u_wdt_top_asserts (.ref_clk(ref_clk),
   .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp), .external_reset_pin_n(external_reset_pin_n),
   .osc_clk_in(osc_clk_in), .sys_clk_stop(sys_clk_stop), .chip_reset_o(chip_reset_o),
   .irq_o(irq_o));

// *** tb_watchdog_reset_timer.sv ***
// Self-checking bench of the watchdog reset timer.
// Assumes the checker is bound to wdt_top; oscillator made here.
`timescale 1ns/1ns
module tb_watchdog_reset_timer;
   logic ref_clk, srst, pin_n, osc, stop, osc_en;
   logic [1:0] oc;
   wdt_pkg::wdt_wb_req_s req;
   wdt_pkg::wdt_wb_rsp_s rsp;
   logic chip_rst, irq;
   logic [7:0] q, v;
   int failures, tests_run, k, n, plen;

   wdt_top #(.PRESC_W(13)) u_wdt_top (.ref_clk(ref_clk), .srst(srst), .wb_req(req),
      .wb_rsp(rsp), .external_reset_pin_n(pin_n), .osc_clk_in(osc), .sys_clk_stop(stop),
      .chip_reset_o(chip_rst), .irq_o(irq));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Oscillator of 8 cycles; pulse length measured beside the tests
   always @(posedge ref_clk) begin
      if (osc_en) begin
         oc <= oc + 2'h1;
         if (oc == 2'h3) osc <= ~osc;
      end
      if (chip_rst === 1'b1) plen <= plen + 1;
   end

   function automatic logic [7:0] ctrl(input logic a, b, c, d);
      return {1'b1, a, 1'b1, b, 1'b1, c, 1'b1, d};
   endfunction : ctrl
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge ref_clk);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h0, d}};
      do begin
         @(posedge ref_clk);
         t++;
      end while (rsp.ack !== 1'b1 && t < 50);
      if (t >= 50) failures++;
      q = rsp.dat[7:0];
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
   endtask : wb
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   initial begin
      #1000000;
      failures++;
      final_report();
   end

   initial begin
      // Pin released and system clock running from the start
      srst = 1'b1;
      pin_n = 1'b1;
      {osc, stop, osc_en, oc} = 5'h00;
      {plen, failures, tests_run} = 96'h0;
      req = '0;
      k = $urandom(25);
      repeat (10) @(posedge ref_clk);
      srst <= 1'b0;
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(0, 0, 0, 0));
      rd(wdt_pkg::OFS_COUNT_VALUE, 8'h00);
      rd(wdt_pkg::OFS_CLOCK_CHOICE, 8'hFF);
      rd(6'h3C, 8'h00);
      v = 8'($urandom_range(255, 1));
      wb(1'b1, wdt_pkg::OFS_COUNT_VALUE, v);
      rd(wdt_pkg::OFS_COUNT_VALUE, 8'h00);
      rd(wdt_pkg::OFS_IRQ_STATUS, 8'h02);
      chk({7'h0, irq}, 8'h00);
      wb(1'b1, wdt_pkg::OFS_IRQ_ENABLE, 8'h03);
      @(posedge ref_clk);
      chk({7'h0, irq}, 8'h01);
      wb(1'b1, wdt_pkg::OFS_IRQ_CLEAR, 8'h02);
      @(posedge ref_clk);
      chk({7'h0, irq}, 8'h00);
      wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'hC0);
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(0, 0, 0, 0));
      wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'h40);
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(1, 0, 0, 0));
      wb(1'b1, wdt_pkg::OFS_COUNT_VALUE, v);
      rd(wdt_pkg::OFS_COUNT_VALUE, v);
      wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'hB4);
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(1, 0, 0, 0));
      // Control enable changed only by a write with bit 5 zero
      wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'hD0);
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(1, 1, 0, 0));
      // Every division: about three ticks in three periods
      for (k = 0; k < 8; k++) begin
         wb(1'b1, wdt_pkg::OFS_CLOCK_CHOICE, 8'(8 + k));
         rd(wdt_pkg::OFS_CLOCK_CHOICE, 8'hF8 + 8'(k));
         wb(1'b1, wdt_pkg::OFS_COUNT_VALUE, 8'h00);
         // Start is a second write after enabling
         wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'h94);
         repeat (3 << (6 + k)) @(posedge ref_clk);
         wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'h90);
         wb(1'b0, wdt_pkg::OFS_COUNT_VALUE, 8'h00);
         chk(8'(q >= 8'h02 && q <= 8'h04), 8'h01);
         v = q;
         repeat (100) @(posedge ref_clk);
         rd(wdt_pkg::OFS_COUNT_VALUE, v);
      end
      stop <= 1'b1;
      wb(1'b1, wdt_pkg::OFS_CLOCK_CHOICE, 8'h08);
      wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'h94);
      repeat (640) @(posedge ref_clk);
      rd(wdt_pkg::OFS_COUNT_VALUE, v);
      wb(1'b1, wdt_pkg::OFS_CLOCK_CHOICE, 8'h00);
      k = $urandom_range(3, 0);
      wb(1'b1, wdt_pkg::OFS_COUNT_VALUE, 8'hFF - 8'(k));
      osc_en <= 1'b1;
      n = 0;
      while (chip_rst !== 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chk(8'(n >= 8 * k && n <= 8 * k + 16), 8'h01);
      chk({7'h0, irq}, 8'h01);
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(1, 1, 1, 1));
      wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'h92);
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(1, 1, 0, 1));
      wb(1'b1, wdt_pkg::OFS_CTRL_STATUS, 8'h98);
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(1, 1, 0, 0));
      wb(1'b1, wdt_pkg::OFS_COUNT_VALUE, 8'h33);
      n = 0;
      while (chip_rst === 1'b1 && n < 6000) begin
         @(posedge ref_clk);
         n++;
      end
      chk(8'(plen >= 4088 && plen <= 4104), 8'h01);
      pin_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      pin_n <= 1'b1;
      rd(wdt_pkg::OFS_COUNT_VALUE, 8'h00);
      rd(wdt_pkg::OFS_CLOCK_CHOICE, 8'hFF);
      rd(wdt_pkg::OFS_CTRL_STATUS, ctrl(0, 0, 0, 0));
      final_report();
   end
endmodule : tb_watchdog_reset_timer
